// File: core/sram_port_defs.svh
// constants for the double-rate burst sram port
// assumes inclusion by the port module only
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH
`define ADDR_W          20
`define DATA_W          18
`define ARRAY_WORDS     1048576
`define BURST_WORDS     3'h4
`define LAT_LONG_EDGES  3'h3
`define LAT_SHORT_EDGES 3'h2
`define C_IDLE_LIMIT    3'h4
`define FIFO_FULL       2'h2
`endif

// File: core/sram_port_pkg.sv
// types for the double-rate burst sram port
// assumes nothing of its surroundings
package sram_port_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } addr_st_t;
endpackage

// File: core/double_rate_burst_sram_port.sv
// double-rate four-word burst sram port, 1m x 18, on one sampling clock
// assumes all pins come asynchronously and are held several clocks
`timescale 1ns/100ps
`include "sram_port_defs.svh"
`default_nettype none
module double_rate_burst_sram_port
    import sram_port_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               srst_i,
    // link clocks
    input  wire logic               k_i,
    input  wire logic               k_n_i,
    input  wire logic               c_i,
    input  wire logic               c_n_i,
    // request pins
    input  wire logic               ld_n_i,
    input  wire logic               rw_i,
    input  wire logic [`ADDR_W-1:0] addr_i,
    input  wire logic               latency_select_i,
    // data pins, shared in and out
    input  wire logic [`DATA_W-1:0] dq_i,
    output logic      [`DATA_W-1:0] dq_o,
    output logic                    dq_oe_o,
    // echo clocks
    output logic                    echo_clk_o,
    output logic                    echo_clk_n_o
);
    localparam int SW = 7 + `ADDR_W + `DATA_W;

    logic [SW-1:0]          s1_q, s2_q;
    logic                   k_s, kn_s, c_s, cn_s, ldn_s, rw_s, lat_s;
    logic [`ADDR_W-1:0]     addr_s;
    logic [`DATA_W-1:0]     dq_s;
    logic [3:0]             prev_q;
    logic                   k_rise, kn_rise, c_rise, cn_rise;
    logic [2:0]             c_idle_q;
    logic                   c_act, l_edge, src_lvl, src_n_lvl;
    addr_st_t               st_q;
    logic                   cap, rd_cap, wr_cap;

    always_ff @(posedge ref_clk_i) begin
        s1_q <= {k_i, k_n_i, c_i, c_n_i, ld_n_i, rw_i, latency_select_i,
                 addr_i, dq_i};
        s2_q <= s1_q;
    end
    assign {k_s, kn_s, c_s, cn_s, ldn_s, rw_s, lat_s, addr_s, dq_s} = s2_q;

    always_ff @(posedge ref_clk_i) begin
        prev_q <= {k_s, kn_s, c_s, cn_s};
    end
    assign k_rise  = k_s & ~prev_q[3];
    assign kn_rise = kn_s & ~prev_q[2];
    assign c_rise  = c_s & ~prev_q[1];
    assign cn_rise = cn_s & ~prev_q[0];

    // c pair counts as supplied while it rose within the last k periods
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            c_idle_q <= `C_IDLE_LIMIT;
        end else if (c_rise) begin
            c_idle_q <= 3'h0;
        end else if (k_rise && c_idle_q != `C_IDLE_LIMIT) begin
            c_idle_q <= c_idle_q + 3'h1;
        end
    end
    assign c_act = (c_idle_q != `C_IDLE_LIMIT);

    assign l_edge    = c_act ? (c_rise | cn_rise) : (k_rise | kn_rise);
    assign src_lvl   = c_act ? c_s : k_s;
    assign src_n_lvl = c_act ? cn_s : kn_s;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_q <= ST_IDLE;
        end else if (k_rise) begin
            case (st_q)
                ST_IDLE: st_q <= ldn_s ? ST_IDLE : ST_HOLD;
                ST_HOLD: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    assign cap    = k_rise && st_q == ST_IDLE && !ldn_s;
    assign rd_cap = cap & rw_s;
    assign wr_cap = cap & ~rw_s;

    // write word capture
    logic [2:0]             wc_rem_q;
    logic [`ADDR_W-3:0]     wc_blk_q;
    logic [1:0]             wc_cnt_q;
    logic                   w_take;
    logic                   hold_v_q;
    logic [`ADDR_W+`DATA_W-1:0] hold_q;
    logic                   f_in_rdy, f_out_v, f_pop;
    logic [1:0]             f_cnt_q;
    logic                   f_wp_q, f_rp_q;
    logic [`ADDR_W+`DATA_W-1:0] f_mem_q [2];
    logic [2:0]             fe_rem_q;

    // word on each k or k_n rise
    assign w_take = (k_rise | kn_rise) && wc_rem_q != 3'h0;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wc_rem_q <= 3'h0;
            wc_blk_q <= '0;
            wc_cnt_q <= 2'h0;
        end else if (wr_cap) begin
            wc_rem_q <= `BURST_WORDS;
            wc_blk_q <= addr_s[`ADDR_W-1:2];
            wc_cnt_q <= addr_s[1:0];
        end else if (w_take) begin
            wc_rem_q <= wc_rem_q - 3'h1;
            wc_cnt_q <= wc_cnt_q + 2'h1; // wraps inside the block
        end
    end

    // holding stage in front of the buffer; a new word wins over the clear after a push
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            hold_v_q <= 1'b0;
            hold_q   <= '0;
        end else if (w_take) begin
            hold_v_q <= 1'b1;
            hold_q   <= {wc_blk_q, wc_cnt_q, dq_s};
        end else if (f_in_rdy) begin
            hold_v_q <= 1'b0;
        end
    end

    // two-entry buffer; reads of the array stall its draining side
    assign f_in_rdy = (f_cnt_q != `FIFO_FULL);
    assign f_out_v  = (f_cnt_q != 2'h0);
    assign f_pop    = f_out_v && fe_rem_q == 3'h0;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            f_cnt_q <= 2'h0;
            f_wp_q  <= 1'b0;
            f_rp_q  <= 1'b0;
        end else begin
            if (hold_v_q && f_in_rdy) begin
                f_mem_q[f_wp_q] <= hold_q;
                f_wp_q          <= ~f_wp_q;
            end
            if (f_pop) begin
                f_rp_q <= ~f_rp_q;
            end
            f_cnt_q <= f_cnt_q + {1'b0, hold_v_q && f_in_rdy}
                               - {1'b0, f_pop};
        end
    end

    logic [`DATA_W-1:0]     mem_q [`ARRAY_WORDS];
    logic [`ADDR_W-1:0]     f_addr;
    assign f_addr = f_mem_q[f_rp_q][`ADDR_W+`DATA_W-1:`DATA_W];

    always_ff @(posedge ref_clk_i) begin
        if (f_pop) begin
            mem_q[f_addr] <= f_mem_q[f_rp_q][`DATA_W-1:0];
        end
    end

    // read fetch into one of two burst banks
    logic [`ADDR_W-3:0]     fe_blk_q;
    logic [1:0]             fe_cnt_q, fe_idx_q;
    logic                   fe_bank_q, rd_bank_q;
    logic [`DATA_W-1:0]     rbuf_q [8];

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fe_rem_q  <= 3'h0;
            fe_blk_q  <= '0;
            fe_cnt_q  <= 2'h0;
            fe_idx_q  <= 2'h0;
            fe_bank_q <= 1'b0;
            rd_bank_q <= 1'b0;
        end else if (rd_cap) begin
            fe_rem_q  <= `BURST_WORDS;
            fe_blk_q  <= addr_s[`ADDR_W-1:2];
            fe_cnt_q  <= addr_s[1:0];
            fe_idx_q  <= 2'h0;
            fe_bank_q <= rd_bank_q;
            rd_bank_q <= ~rd_bank_q;
        end else if (fe_rem_q != 3'h0) begin
            rbuf_q[{fe_bank_q, fe_idx_q}] <= mem_q[{fe_blk_q, fe_cnt_q}];
            fe_rem_q <= fe_rem_q - 3'h1;
            fe_cnt_q <= fe_cnt_q + 2'h1;
            fe_idx_q <= fe_idx_q + 2'h1;
        end
    end

    // latency counted in k-pair edges, launch on the next launch-pair edge;
    // counting c edges would let a lagging c rise cut half a cycle
    logic                   pend_v_q, pend_bank_q, act_bank_q, start;
    logic                   kp_edge;
    logic [2:0]             pend_cnt_q, act_rem_q;
    logic [1:0]             act_idx_q;
    assign kp_edge = k_rise | kn_rise;
    assign start   = l_edge && pend_v_q
                     && (pend_cnt_q == 3'h0
                         || (pend_cnt_q == 3'h1 && kp_edge));

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pend_v_q    <= 1'b0;
            pend_cnt_q  <= 3'h0;
            pend_bank_q <= 1'b0;
        end else if (rd_cap) begin
            pend_v_q    <= 1'b1;
            pend_cnt_q  <= lat_s ? `LAT_LONG_EDGES : `LAT_SHORT_EDGES;
            pend_bank_q <= rd_bank_q;
        end else if (start) begin
            pend_v_q   <= 1'b0;
        end else if (kp_edge && pend_v_q && pend_cnt_q != 3'h0) begin
            pend_cnt_q <= pend_cnt_q - 3'h1;
        end
    end

    // data on shared pins per edge
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            dq_o       <= '0;
            dq_oe_o    <= 1'b0;
            act_rem_q  <= 3'h0;
            act_idx_q  <= 2'h0;
            act_bank_q <= 1'b0;
        end else if (start) begin
            dq_o       <= rbuf_q[{pend_bank_q, 2'h0}];
            dq_oe_o    <= 1'b1;
            act_rem_q  <= `BURST_WORDS - 3'h1;
            act_idx_q  <= 2'h1;
            act_bank_q <= pend_bank_q;
        end else if (l_edge && act_rem_q != 3'h0) begin
            dq_o      <= rbuf_q[{act_bank_q, act_idx_q}];
            act_rem_q <= act_rem_q - 3'h1;
            act_idx_q <= act_idx_q + 2'h1;
        end else if (l_edge) begin
            dq_oe_o <= 1'b0; // release one edge after the last word
        end
    end

    // echo clocks retimed with the data so both share one delay
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            echo_clk_o   <= 1'b0;
            echo_clk_n_o <= 1'b0;
        end else begin
            echo_clk_o   <= src_lvl;
            echo_clk_n_o <= src_n_lvl;
        end
    end

    // helper: k-pair edges seen since the last read capture
    logic [2:0] lat_ctr_q;
    logic       lat_cap_q;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || rd_cap) begin
            lat_ctr_q <= 3'h0;
            lat_cap_q <= lat_s;
        end else if (kp_edge && lat_ctr_q != 3'h7) begin
            lat_ctr_q <= lat_ctr_q + 3'h1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    sequence burst_start_s;
        start;
    endsequence
    sequence oe_on_s;
        dq_oe_o && dq_o == $past(rbuf_q[{pend_bank_q, 2'h0}]);
    endsequence

    AST_ADDR_ALT: assert property (
        cap |=> st_q == ST_HOLD && !cap)
        else $error("address taken on back-to-back k rise");
    AST_WR_BURST: assert property (
        wr_cap |=> wc_rem_q == `BURST_WORDS)
        else $error("write burst not armed for four words");
    AST_C_SRC: assert property (
        c_act && !c_rise && !cn_rise && !start |=> $stable(dq_o))
        else $error("data moved without a c pair edge");
    AST_BURST_CNT: assert property (
        fe_rem_q != 3'h0 && !rd_cap |=>
            fe_cnt_q == 2'($past(fe_cnt_q) + 2'h1)
            && fe_blk_q == $past(fe_blk_q))
        else $error("burst counter did not step in block");
    AST_LAT_LONG: assert property (
        start && lat_cap_q |-> lat_ctr_q + {2'h0, kp_edge} == 3'h3)
        else $error("long latency launch on wrong edge");
    AST_LAT_SHORT: assert property (
        start && !lat_cap_q |-> lat_ctr_q + {2'h0, kp_edge} == 3'h2)
        else $error("short latency launch on wrong edge");
    AST_DRAIN: assert property (
        f_pop |-> fe_rem_q == 3'h0 ##1 f_cnt_q != `FIFO_FULL)
        else $error("array write collided with a fetch");
    AST_OE_BURST: assert property (
        burst_start_s |=> oe_on_s)
        else $error("first read word not driven");
    AST_SYNC: assert property (
        k_rise |-> $past(k_i, 2) && !$past(k_i, 3))
        else $error("k edge seen without two-stage sync");
    AST_RISE_ONLY: assert property (
        w_take |-> ($past(k_i, 2) && !$past(k_i, 3))
                   || ($past(k_n_i, 2) && !$past(k_n_i, 3)))
        else $error("write word taken off a rising edge");
endmodule
`default_nettype wire

// File: test/ctl_model.sv
// memory controller model: link clocks, requests, write words
// assumes the bench calls req() and sets c_on; k runs free
`timescale 1ns/100ps
`default_nettype none
module ctl_model (
    // link pins
    output logic        k_o,
    output logic        k_n_o,
    output logic        c_o,
    output logic        c_n_o,
    output logic        ld_n_o,
    output logic        rw_o,
    output logic [19:0] addr_o,
    output logic        lat_o,
    output logic [17:0] wd_o
);
    logic        c_on = 1'b0;
    realtime     t_cap;
    logic [17:0] wq [$];
    // free-running k, each edge 12 ns ahead of a bench clock rise
    initial begin
        k_o = 1'b0;
        ld_n_o = 1'b1;
        rw_o = 1'b1;
        addr_o = 20'h0;
        lat_o = 1'b1;
        wd_o = 18'h0;
        #13;
        forever #200 k_o = ~k_o;
    end
    assign k_n_o = ~k_o;
    // output pair lags k; stands low when not supplied
    always @(k_o) c_o <= #40 c_on & k_o;
    assign c_n_o = c_on & ~c_o;
    // word ahead of each k and k_n rise
    always @(k_o) begin
        #100;
        wd_o = (wq.size() != 0) ? wq.pop_front() : ~wd_o; // idle bus flips
    end
    // request held over one k rise, or over two when ext is set
    task automatic req(input logic rd, input logic [19:0] a,
                       input logic [71:0] w, input logic ext,
                       input logic lt);
        @(negedge k_o);
        #5;
        ld_n_o = 1'b0;
        rw_o = rd;
        addr_o = a;
        lat_o = lt;
        @(posedge k_o);
        t_cap = $realtime;
        for (int i = 0; i < 4 && !rd; i++) wq.push_back(w[18*i +: 18]);
        @(negedge k_o);
        #5;
        // ext keeps a write pending into the refused slot
        if (ext) begin
            rw_o = 1'b0;
            addr_o = a ^ 20'h6;
            @(negedge k_o);
            #5;
        end
        ld_n_o = 1'b1;
        rw_o = ~rw_o;
        addr_o = ~addr_o;
    endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the double-rate burst sram port
// assumes the controller model drives every link pin
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        k, k_n, c, c_n, ld_n, rw, lat, dq_oe_o;
    logic        echo_clk_o, echo_clk_n_o;
    logic [19:0] addr;
    logic [17:0] wd, dq_o, dq_i;
    logic [17:0] mem [logic [19:0]];
    logic [31:0] lf = 32'h7fd8;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;
    logic [19:0] pa, a;
    // bench clock
    always #25 ref_clk = ~ref_clk;
    // shared data wire: device wins while it drives
    assign dq_i = dq_oe_o ? dq_o : wd;
    ctl_model ctl (.k_o(k), .k_n_o(k_n), .c_o(c), .c_n_o(c_n),
        .ld_n_o(ld_n), .rw_o(rw), .addr_o(addr), .lat_o(lat), .wd_o(wd));
    double_rate_burst_sram_port dut (.ref_clk_i(ref_clk), .srst_i(srst),
        .k_i(k), .k_n_i(k_n), .c_i(c), .c_n_i(c_n), .ld_n_i(ld_n),
        .rw_i(rw), .addr_i(addr), .latency_select_i(lat), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o), .echo_clk_o(echo_clk_o),
        .echo_clk_n_o(echo_clk_n_o));
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // burst word i stays in the aligned block
    function automatic logic [19:0] ba(input logic [19:0] x, input int i);
        return {x[19:2], x[1:0] + 2'(i)};
    endfunction
    task automatic close_out;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // samples each word 90 ns after a k-pair launch, 40 ns after a c-pair launch, clear of ref edges
    task automatic rd_chk(input logic [19:0] x, input int n,
                          input logic iso, input realtime t0);
        logic [17:0] e [4];
        for (int i = 0; i < 4; i++) e[i] = mem[ba(x, i)];
        #(t0 + n * 200 + 2 - $realtime);
        if (iso) chk(dq_oe_o === 1'b0, "data too early");
        for (int i = 0; i < 4; i++) begin
            #200;
            chk(dq_oe_o === 1'b1 && dq_o === e[i], "read word");
            chk(echo_clk_o === ((n + i) % 2 == 0), "echo phase");
            chk(echo_clk_n_o === ~echo_clk_o, "echo pair");
        end
        #200;
        if (iso) chk(dq_oe_o === 1'b0, "bus not freed");
    endtask
    task automatic wr(input logic [19:0] x, input logic ext);
        logic [71:0] w;
        lf = nx(lf);
        w[35:0] = {lf, 4'h5};
        lf = nx(lf);
        w[71:36] = {lf, 4'ha};
        ctl.req(1'b0, x, w, ext, lf[3]);
        for (int i = 0; i < 4; i++) mem[ba(x, i)] = w[18*i +: 18];
    endtask
    task automatic rd(input logic [19:0] x, input logic lt, input logic iso);
        ctl.req(1'b1, x, 72'h0, 1'b0, lt);
        fork
            rd_chk(x, lt ? 3 : 2, iso, ctl.t_cap);
        join_none
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        #5 srst = 1'b0;
        repeat (4) @(posedge ref_clk);
        chk(dq_oe_o === 1'b0 && dq_o === 18'h0, "idle after reset");
        wr(20'h00100, 1'b0);
        wr(20'h00106, 1'b1);
        rd(20'h00103, 1'b1, 1'b1);
        repeat (40) @(posedge ref_clk);
        rd(20'h00105, 1'b0, 1'b1);
        repeat (40) @(posedge ref_clk);
        pa = 20'h00106;
        for (int j = 0; j < 24; j++) begin
            if (j == 12) ctl.c_on = 1'b1;
            lf = nx(lf);
            a = lf[19:0];
            wr(a, 1'b0);
            rd({pa[19:2], lf[23:22]}, lf[24], 1'b0);
            pa = a;
            // bus turnaround: next write words only after the burst ends
            repeat (24) @(posedge ref_clk);
        end
        repeat (40) @(posedge ref_clk);
        ctl.c_on = 1'b0;
        repeat (60) @(posedge ref_clk);
        rd({pa[19:2], 2'h1}, 1'b1, 1'b1);
        repeat (60) @(posedge ref_clk);
        close_out();
    end
endmodule
`default_nettype wire
